// ===== brt_bank.v
// Four-channel baud-rate timer bank with AXI4-Lite register slave
//
// How it works
// - Per-timer bit picks symmetric or narrow pulse
// - Symmetric period is 2*(N+1) count clocks
// - Narrow period N+1; software avoids N=0
// - Timer counts only while its enable set
// - Base clock bit: 0 system, 1 slow
// - Selector 0-8 divides base by 2^sel
// - Selector 9-15 divides system clock 1..64
// - Two selectors share register, odd upper
// - Eight-bit compare register per timer
// - Upper four control bits read zero
// - Counter clears on tick after match
//
// Register access over AXI4-Lite and the address map were left to the implementer.
`include "brt_defs.vh"

module brt_bank (
  input wire core_clk,
  input wire rst_n,
  input wire slow_clk_pin,
  input wire [31:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  output wire [3:0] timer_output_clock
);

  // Mask of low bits that must be all ones for a divide by 2^k tick
  function [7:0] div_mask;
    input [3:0] k;
    begin
      case (k)
        4'h0: div_mask = 8'h00;
        4'h1: div_mask = 8'h01;
        4'h2: div_mask = 8'h03;
        4'h3: div_mask = 8'h07;
        4'h4: div_mask = 8'h0F;
        4'h5: div_mask = 8'h1F;
        4'h6: div_mask = 8'h3F;
        4'h7: div_mask = 8'h7F;
        default: div_mask = 8'hFF;
      endcase
    end
  endfunction

  // Count clock enable for one timer from its selector and base choice
  function count_tick_of;
    input [3:0] sel;
    input base_slow;
    input [7:0] sys_cnt;
    input [7:0] slow_cnt;
    input slow_tick;
    reg [7:0] m;
    begin
      m = 8'h00;
      if (sel > `BRT_SEL_BASE_MAX) begin
        m = div_mask(sel - `BRT_SEL_SYS_BASE);
        count_tick_of = ((sys_cnt & m) == m);
      end else begin
        m = div_mask(sel);
        if (base_slow) begin
          count_tick_of = slow_tick & ((slow_cnt & m) == m);
        end else begin
          count_tick_of = ((sys_cnt & m) == m);
        end
      end
    end
  endfunction

  reg [3:0] duty_mode_q;
  reg [3:0] count_enable_q;
  reg [3:0] base_sel_q;
  reg [7:0] prescale01_q;
  reg [7:0] prescale23_q;
  reg [7:0] compare0_q;
  reg [7:0] compare1_q;
  reg [7:0] compare2_q;
  reg [7:0] compare3_q;
  reg [7:0] sys_div_q;
  reg [7:0] slow_div_q;
  reg slow_sync1_q;
  reg slow_sync2_q;
  reg slow_prev_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;
  reg [31:0] rdata_d;
  reg [1:0] rresp_d;
  reg wr_hit;
  wire slow_tick;
  wire wr_go;
  wire rd_go;
  wire [`BRT_ADDR_W-1:0] wa;
  wire [`BRT_ADDR_W-1:0] ra;
  wire [7:0] wb;
  wire [3:0] tick;
  wire [7:0] cmp [0:3];
  wire [3:0] sel [0:3];

  // Slow base clock pin crosses in through two flops before edge detect
  always @(posedge core_clk) begin
    if (!rst_n) begin
      slow_sync1_q <= 1'b0;
      slow_sync2_q <= 1'b0;
      slow_prev_q <= 1'b0;
    end else begin
      slow_sync1_q <= slow_clk_pin;
      slow_sync2_q <= slow_sync1_q;
      slow_prev_q <= slow_sync2_q;
    end
  end

  // Rising edge of the slow clock is one count of the slow base
  assign slow_tick = slow_sync2_q & ~slow_prev_q;

  // Free-running prescalers shared by all timers, so ratios stay exact
  always @(posedge core_clk) begin
    if (!rst_n) begin
      sys_div_q <= 8'h00;
      slow_div_q <= 8'h00;
    end else begin
      sys_div_q <= sys_div_q + 8'h01;
      if (slow_tick) begin
        slow_div_q <= slow_div_q + 8'h01;
      end
    end
  end

  assign sel[0] = prescale01_q[`BRT_LOW_NIBBLE];
  assign sel[1] = prescale01_q[`BRT_HIGH_NIBBLE];
  assign sel[2] = prescale23_q[`BRT_LOW_NIBBLE];
  assign sel[3] = prescale23_q[`BRT_HIGH_NIBBLE];
  assign cmp[0] = compare0_q;
  assign cmp[1] = compare1_q;
  assign cmp[2] = compare2_q;
  assign cmp[3] = compare3_q;

  // Per-timer count enables and timer instances
  genvar g;
  generate
    for (g = 0; g < `BRT_NUM_TIMERS; g = g + 1) begin : g_tmr
      assign tick[g] = count_tick_of(sel[g], base_sel_q[g], sys_div_q,
                                     slow_div_q, slow_tick);
      brt_timer u_timer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .count_enable_bit(count_enable_q[g]),
        .duty_mode_bit(duty_mode_q[g]),
        .count_tick(tick[g]),
        .compare_value(cmp[g]),
        .timer_output_clock(timer_output_clock[g])
      );
    end
  endgenerate

  // Write takes address and data together; one response outstanding
  assign wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign wa = s_axi_awaddr[`BRT_ADDR_W-1:0];
  assign wb = s_axi_wdata[7:0];

  // Decode of the write address; high address bits must be clear
  always @* begin
    wr_hit = 1'b0;
    if (s_axi_awaddr[31:`BRT_ADDR_W] != 24'h000000) begin
      wr_hit = 1'b0;
    end else if (wa == `BRT_ADDR_DUTY_MODE) begin
      wr_hit = 1'b1;
    end else if (wa == `BRT_ADDR_COUNT_EN) begin
      wr_hit = 1'b1;
    end else if (wa == `BRT_ADDR_BASE_SEL) begin
      wr_hit = 1'b1;
    end else if (wa == `BRT_ADDR_PRESCALE01) begin
      wr_hit = 1'b1;
    end else if (wa == `BRT_ADDR_PRESCALE23) begin
      wr_hit = 1'b1;
    end else if (wa == `BRT_ADDR_COMPARE0) begin
      wr_hit = 1'b1;
    end else if (wa == `BRT_ADDR_COMPARE1) begin
      wr_hit = 1'b1;
    end else if (wa == `BRT_ADDR_COMPARE2) begin
      wr_hit = 1'b1;
    end else if (wa == `BRT_ADDR_COMPARE3) begin
      wr_hit = 1'b1;
    end
  end

  // Register writes; only byte lane 0 carries data
  always @(posedge core_clk) begin
    if (!rst_n) begin
      duty_mode_q <= `BRT_RST_CTRL;
      count_enable_q <= `BRT_RST_CTRL;
      base_sel_q <= `BRT_RST_CTRL;
      prescale01_q <= `BRT_RST_PRESCALE;
      prescale23_q <= `BRT_RST_PRESCALE;
      compare0_q <= `BRT_RST_COMPARE;
      compare1_q <= `BRT_RST_COMPARE;
      compare2_q <= `BRT_RST_COMPARE;
      compare3_q <= `BRT_RST_COMPARE;
    end else if (wr_go && wr_hit && s_axi_wstrb[0]) begin
      if (wa == `BRT_ADDR_DUTY_MODE) begin
        duty_mode_q <= wb[3:0];
      end else if (wa == `BRT_ADDR_COUNT_EN) begin
        count_enable_q <= wb[3:0];
      end else if (wa == `BRT_ADDR_BASE_SEL) begin
        base_sel_q <= wb[3:0];
      end else if (wa == `BRT_ADDR_PRESCALE01) begin
        prescale01_q <= wb;
      end else if (wa == `BRT_ADDR_PRESCALE23) begin
        prescale23_q <= wb;
      end else if (wa == `BRT_ADDR_COMPARE0) begin
        compare0_q <= wb;
      end else if (wa == `BRT_ADDR_COMPARE1) begin
        compare1_q <= wb;
      end else if (wa == `BRT_ADDR_COMPARE2) begin
        compare2_q <= wb;
      end else if (wa == `BRT_ADDR_COMPARE3) begin
        compare3_q <= wb;
      end
    end
  end

  // Write response one cycle after the handshake
  always @(posedge core_clk) begin
    if (!rst_n) begin
      bvalid_q <= 1'b0;
      bresp_q <= `BRT_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? `BRT_RESP_OKAY : `BRT_RESP_DECERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read side: one read in flight, data registered
  assign rd_go = s_axi_arvalid & ~rvalid_q;
  assign s_axi_arready = rd_go;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign ra = s_axi_araddr[`BRT_ADDR_W-1:0];

  // Read mux; unmapped addresses give zero data and a decode error
  always @* begin
    rdata_d = 32'h00000000;
    rresp_d = `BRT_RESP_OKAY;
    if (s_axi_araddr[31:`BRT_ADDR_W] != 24'h000000) begin
      rresp_d = `BRT_RESP_DECERR;
    end else if (ra == `BRT_ADDR_DUTY_MODE) begin
      rdata_d = {28'h0000000, duty_mode_q};
    end else if (ra == `BRT_ADDR_COUNT_EN) begin
      rdata_d = {28'h0000000, count_enable_q};
    end else if (ra == `BRT_ADDR_BASE_SEL) begin
      rdata_d = {28'h0000000, base_sel_q};
    end else if (ra == `BRT_ADDR_PRESCALE01) begin
      rdata_d = {24'h000000, prescale01_q};
    end else if (ra == `BRT_ADDR_PRESCALE23) begin
      rdata_d = {24'h000000, prescale23_q};
    end else if (ra == `BRT_ADDR_COMPARE0) begin
      rdata_d = {24'h000000, compare0_q};
    end else if (ra == `BRT_ADDR_COMPARE1) begin
      rdata_d = {24'h000000, compare1_q};
    end else if (ra == `BRT_ADDR_COMPARE2) begin
      rdata_d = {24'h000000, compare2_q};
    end else if (ra == `BRT_ADDR_COMPARE3) begin
      rdata_d = {24'h000000, compare3_q};
    end else begin
      rresp_d = `BRT_RESP_DECERR;
    end
  end

  // Read data held until the master takes it
  always @(posedge core_clk) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `BRT_RESP_OKAY;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule // brt_bank

// ===== brt_bank_monitor.sv
// Bus and output-clock checks for the timer bank
module brt_bank_monitor (
  input wire core_clk,
  input wire rst_n,
  input wire s_axi_awvalid,
  input wire s_axi_wvalid,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire [3:0] timer_output_clock
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Answers come one cycle after the take, once each
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid)
    else $error("write not answered");
  a_write_once: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
  a_write_cause: assert property (
    $rose(s_axi_bvalid) |-> $past(s_axi_awvalid && s_axi_wvalid))
    else $error("bvalid without write");
  a_addr_data_pair: assert property (
    s_axi_awready |-> s_axi_wready && s_axi_awvalid && s_axi_wvalid)
    else $error("address taken alone");
  a_read_answer: assert property (
    s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid) else $error("read late");
  a_read_once: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
  // Fields are at most eight bits wide
  a_rdata_narrow: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_decerr_zero: assert property (
    s_axi_rvalid && s_axi_rresp == 2'h3 |-> s_axi_rdata == 32'h00000000)
    else $error("refused read carries data");
  a_out_reset: assert property (
    $rose(rst_n) |-> timer_output_clock == 4'h0) else $error("clock after reset");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_narrow: cover property ($rose(timer_output_clock[3]));
endmodule // brt_bank_monitor

bind brt_bank brt_bank_monitor i_mon (.core_clk, .rst_n, .s_axi_awvalid,
  .s_axi_wvalid, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .s_axi_rresp, .timer_output_clock);

// ===== brt_bank_tb_top.sv
// Self-checking bench for the baud-rate timer bank
`include "brt_defs.vh"
module brt_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, rst_n = 1'b0, slow_clk_pin = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [3:0] timer_output_clock;
  wire [63:0] per, hi;
  int n_mismatch = 0, cmp_count = 0, slow_div = 0;

  always #2 core_clk = ~core_clk;
  // Slow pin: 20 core cycles a period
  always @(posedge core_clk) begin
    slow_div <= (slow_div == 9) ? 0 : slow_div + 1;
    if (slow_div == 9) slow_clk_pin <= ~slow_clk_pin;
  end

  brt_bank i_dut (.core_clk, .rst_n, .slow_clk_pin, .s_axi_awaddr,
    .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .timer_output_clock);
  brt_chan_model i_ch[3:0] (.core_clk, .clk_in(timer_output_clock),
    .period(per), .high_len(hi));

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task close_out();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // One write or read; read compares data against d
  task bus(input bit w, input logic [7:0] a, input logic [31:0] d,
           input logic [1:0] er);
    int n;
    n = 0;
    @(posedge core_clk);
    s_axi_awaddr <= {24'h000000, a};
    s_axi_araddr <= {24'h000000, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    do begin
      @(posedge core_clk);
      n++;
    end while ((w ? s_axi_awready : s_axi_arready) !== 1'b1 && n < 99);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge core_clk);
      n++;
    end while ((w ? s_axi_bvalid : s_axi_rvalid) !== 1'b1 && n < 99);
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    // Timeout ends the run here; otherwise judge the answer
    if (n >= 99) begin
      n_mismatch++;
      close_out();
    end else begin
      chk("resp", w ? s_axi_bresp : s_axi_rresp, er);
      if (!w) chk("rdata", s_axi_rdata, d);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, `BRT_RESP_OKAY);
  endtask

  // Waits cyc core clocks (none when zero), then compares the last measured shape
  task meas(input int t, input int cyc, input logic [15:0] ep, eh);
    repeat (cyc) @(posedge core_clk);
    chk("period", per[t*16 +: 16], ep);
    chk("high", hi[t*16 +: 16], eh);
  endtask

  task t_reset();
    for (int i = 0; i < 5; i++)
      bus(1'b0, 8'(4 * i), 32'h0, `BRT_RESP_OKAY);
  endtask

  task t_regs();
    // Compares loaded first, so no timer runs narrow on zero
    for (int i = 0; i < 4; i++)
      wr(`BRT_ADDR_COMPARE0 + 8'(4 * i), 32'h1);
    for (int i = 0; i < 3; i++) begin
      wr(8'(4 * i), 32'hFFFFFFFF);
      bus(1'b0, 8'(4 * i), 32'h0000000F, `BRT_RESP_OKAY);
    end
    wr(`BRT_ADDR_PRESCALE01, 32'hA5);
    bus(1'b0, `BRT_ADDR_PRESCALE01, 32'hA5, `BRT_RESP_OKAY);
    wr(`BRT_ADDR_COMPARE3, 32'h1FF);
    bus(1'b0, `BRT_ADDR_COMPARE3, 32'hFF, `BRT_RESP_OKAY);
    // Lane 0 strobe low must leave the byte as it was
    @(posedge core_clk);
    s_axi_wstrb <= 4'h0;
    wr(`BRT_ADDR_COMPARE3, 32'h12);
    s_axi_wstrb <= 4'hF;
    bus(1'b0, `BRT_ADDR_COMPARE3, 32'hFF, `BRT_RESP_OKAY);
    bus(1'b1, 8'h24, 32'h1, `BRT_RESP_DECERR);
    bus(1'b0, 8'h24, 32'h0, `BRT_RESP_DECERR);
    wr(`BRT_ADDR_COUNT_EN, 32'h0);
  endtask

  // Mixed modes and selectors, all four running together
  task t_rates();
    wr(`BRT_ADDR_DUTY_MODE, 32'h8);
    wr(`BRT_ADDR_BASE_SEL, 32'h0);
    wr(`BRT_ADDR_PRESCALE01, 32'h92);
    wr(`BRT_ADDR_PRESCALE23, 32'h1F);
    wr(`BRT_ADDR_COMPARE0, 32'h2);
    wr(`BRT_ADDR_COMPARE1, 32'h3);
    wr(`BRT_ADDR_COMPARE2, 32'h0);
    wr(`BRT_ADDR_COMPARE3, 32'h3);
    wr(`BRT_ADDR_COUNT_EN, 32'hF);
    meas(2, 600, 16'h80, 16'h40);
    meas(0, 0, 16'h18, 16'hC);
    meas(1, 0, 16'h8, 16'h4);
    meas(3, 0, 16'h8, 16'h2);
  endtask

  // Slow base on timer 0 (stopped while reconfigured), base/256 on timer 2
  task t_slow();
    wr(`BRT_ADDR_COUNT_EN, 32'hE);
    wr(`BRT_ADDR_BASE_SEL, 32'h1);
    wr(`BRT_ADDR_PRESCALE01, 32'h90);
    wr(`BRT_ADDR_PRESCALE23, 32'h08);
    wr(`BRT_ADDR_COMPARE0, 32'h0);
    wr(`BRT_ADDR_COMPARE1, 32'h5);
    wr(`BRT_ADDR_COUNT_EN, 32'hF);
    meas(0, 300, 16'h28, 16'h14);
    meas(3, 0, 16'h4, 16'h1);
    meas(1, 0, 16'hC, 16'h6);
    meas(2, 600, 16'h200, 16'h100);
  endtask

  task t_stop();
    logic [3:0] seen;
    wr(`BRT_ADDR_COUNT_EN, 32'hD);
    repeat (3) @(posedge core_clk);
    seen = 4'h0;
    repeat (60) @(posedge core_clk) seen = seen | timer_output_clock;
    chk("one off", seen & 4'hA, 4'h8);
    wr(`BRT_ADDR_COUNT_EN, 32'h0);
    repeat (3) @(posedge core_clk);
    seen = 4'h0;
    repeat (60) @(posedge core_clk) seen = seen | timer_output_clock;
    chk("all off", seen, 4'h0);
  endtask

  initial begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_rates();
    t_slow();
    t_stop();
    close_out();
  end
endmodule // brt_bank_tb_top

// ===== brt_chan_model.sv
// Serial-channel side model: measures period and high time of its clock
module brt_chan_model (
  input wire core_clk,
  input wire clk_in,
  output logic [15:0] period,
  output logic [15:0] high_len
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev_q;
  logic [15:0] cnt_q;
  logic [15:0] hcnt_q;
  // edges only
  // Only measures; never shifts data off an undivided narrow pulse
  always @(posedge core_clk) begin
    prev_q <= clk_in;
    cnt_q <= (clk_in && !prev_q) ? 16'h0001 : cnt_q + 16'h0001;
    hcnt_q <= clk_in ? hcnt_q + 16'h0001 : 16'h0000;
    if (clk_in && !prev_q) period <= cnt_q;
    if (!clk_in && prev_q) high_len <= hcnt_q;
  end
endmodule // brt_chan_model

// ===== brt_defs.vh
// Register map, field layout and reset values of the baud-rate timer bank
`ifndef BRT_DEFS_VH
`define BRT_DEFS_VH

// Register byte addresses on the AXI4-Lite bus
`define BRT_ADDR_DUTY_MODE 8'h00
`define BRT_ADDR_COUNT_EN 8'h04
`define BRT_ADDR_BASE_SEL 8'h08
`define BRT_ADDR_PRESCALE01 8'h0C
`define BRT_ADDR_PRESCALE23 8'h10
`define BRT_ADDR_COMPARE0 8'h14
`define BRT_ADDR_COMPARE1 8'h18
`define BRT_ADDR_COMPARE2 8'h1C
`define BRT_ADDR_COMPARE3 8'h20
`define BRT_ADDR_W 8

// Field layout
`define BRT_NUM_TIMERS 4
`define BRT_LOW_NIBBLE 3:0
`define BRT_HIGH_NIBBLE 7:4

// Reset values
`define BRT_RST_CTRL 4'h0
`define BRT_RST_PRESCALE 8'h00
`define BRT_RST_COMPARE 8'h00

// Count clock selector codes
`define BRT_SEL_BASE_MAX 4'h8
`define BRT_SEL_SYS_BASE 4'h9

// AXI response codes
`define BRT_RESP_OKAY 2'h0
`define BRT_RESP_DECERR 2'h3

`endif

// ===== brt_timer.v
// One baud-rate timer: up counter, compare wrap and output clock shaping
module brt_timer (
  input wire core_clk,
  input wire rst_n,
  input wire count_enable_bit,
  input wire duty_mode_bit,
  input wire count_tick,
  input wire [7:0] compare_value,
  output wire timer_output_clock
);

  reg [7:0] up_counter_q;
  reg out_q;
  wire wrap;

  // Counter has reached the compare value
  assign wrap = (up_counter_q == compare_value);
  assign timer_output_clock = out_q;

  // Counter and output advance only on the selected count clock
  always @(posedge core_clk) begin
    if (!rst_n) begin
      up_counter_q <= 8'h00;
      out_q <= 1'b0;
    end else if (!count_enable_bit) begin
      up_counter_q <= 8'h00;
      out_q <= 1'b0;
    end else if (count_tick) begin
      if (wrap) begin
        up_counter_q <= 8'h00;
      end else begin
        up_counter_q <= up_counter_q + 8'h01;
      end
      if (duty_mode_bit) begin
        out_q <= wrap;
      end else if (wrap) begin
        out_q <= ~out_q;
      end
    end
  end

endmodule // brt_timer
